// ---- pchb_config_bars.sv ----
`timescale 1ns/100ps
`include "pchb_map.svh"

module pchb_config_bars
    import pchb_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          reset_n,
    input  wire pchb_cfg_req_t cfgReq,
    output logic [31:0]        cfgRdata,
    output logic               cfgRdValid,
    input  wire pchb_mem_req_t memReq,
    output logic               hitStatusCtrl,
    output logic               hitControlSpace
);

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function automatic logic [31:0] laneMerge(input logic [31:0] oldVal,
                                              input logic [31:0] newVal,
                                              input logic [3:0]  be,
                                              input logic [31:0] mask);
        logic [31:0] res;
        res = oldVal;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = newVal[i*8 +: 8];
            end
        end
        return res & mask;
    endfunction

    function automatic logic dwSel(input logic [7:0] addr, input logic [7:0] ofs);
        return addr[7:2] == ofs[7:2];
    endfunction

    // ------------------------------------------------------------------------
    // Window base registers
    // ------------------------------------------------------------------------
    logic [31:0] scwBase_r;
    logic [31:0] cswBase_r;

    // The mask keeps the fixed low bits at zero in the flop itself, so no
    // read path can ever expose a written low bit.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            scwBase_r <= `PCHB_BASE_RST;
        end else if (cfgReq.wr && dwSel(cfgReq.addr, `PCHB_OFS_SCW_BASE)) begin
            scwBase_r <= laneMerge(scwBase_r, cfgReq.wdata, cfgReq.byteEn, `PCHB_SCW_MASK);
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cswBase_r <= `PCHB_BASE_RST;
        end else if (cfgReq.wr && dwSel(cfgReq.addr, `PCHB_OFS_CSW_BASE)) begin
            cswBase_r <= laneMerge(cswBase_r, cfgReq.wdata, cfgReq.byteEn, `PCHB_CSW_MASK);
        end
    end

    // ------------------------------------------------------------------------
    // Configuration read path
    // ------------------------------------------------------------------------
    logic [31:0] rdData_nxt;

    always_comb begin
        rdData_nxt = 32'h00000000;
        if (dwSel(cfgReq.addr, `PCHB_OFS_DW_MISC)) begin
            // Byte 0 belongs to a neighbouring register and reads zero here.
            rdData_nxt = {`PCHB_SELFTEST_VAL,
                          `PCHB_HEADER_VAL,
                          `PCHB_LATENCY_VAL,
                          8'h00};
        end else if (dwSel(cfgReq.addr, `PCHB_OFS_SCW_BASE)) begin
            rdData_nxt = scwBase_r;
        end else if (dwSel(cfgReq.addr, `PCHB_OFS_CSW_BASE)) begin
            rdData_nxt = cswBase_r;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cfgRdata   <= 32'h00000000;
            cfgRdValid <= 1'b0;
        end else begin
            cfgRdValid <= cfgReq.rd;
            if (cfgReq.rd) begin
                cfgRdata <= rdData_nxt;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Memory window decode
    // ------------------------------------------------------------------------
    logic scwMatch;
    logic cswMatch;

    assign scwMatch = (memReq.addr & `PCHB_SCW_MASK) == scwBase_r;
    assign cswMatch = (memReq.addr & `PCHB_CSW_MASK) == cswBase_r;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            hitStatusCtrl   <= 1'b0;
            hitControlSpace <= 1'b0;
        end else begin
            hitStatusCtrl   <= memReq.valid && memReq.spaceEnable && scwMatch;
            hitControlSpace <= memReq.valid && memReq.spaceEnable && cswMatch;
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    AST_MISC_DW_ZERO: assert property (
        @(posedge clk) disable iff (!reset_n)
        (cfgReq.rd && dwSel(cfgReq.addr, `PCHB_OFS_DW_MISC)) |=> (cfgRdValid && cfgRdata == 32'h0))
        else $error("Constant dword did not read as zero.");

    AST_HEADER_ZERO: assert property (
        @(posedge clk) disable iff (!reset_n)
        (cfgReq.rd && dwSel(cfgReq.addr, `PCHB_OFS_HEADER)) |=> cfgRdata[23:16] == 8'h00)
        else $error("Header type byte not zero.");

    AST_SELFTEST_ZERO: assert property (
        @(posedge clk) disable iff (!reset_n)
        (cfgReq.rd && dwSel(cfgReq.addr, `PCHB_OFS_SELFTEST)) ##1 1'b1 |-> cfgRdata[31:24] == 8'h00)
        else $error("Self-test byte not zero.");

    AST_SCW_STORE: assert property (
        @(posedge clk) disable iff (!reset_n)
        (cfgReq.wr && dwSel(cfgReq.addr, `PCHB_OFS_SCW_BASE) && cfgReq.byteEn == 4'hf)
        |=> scwBase_r == ($past(cfgReq.wdata) & `PCHB_SCW_MASK))
        else $error("Status/control base write not stored.");

    AST_SCW_LOW_ZERO: assert property (
        @(posedge clk) disable iff (!reset_n)
        $past(cfgReq.rd && dwSel(cfgReq.addr, `PCHB_OFS_SCW_BASE)) |-> cfgRdata[11:0] == 12'h000)
        else $error("Status/control base low bits not zero.");

    AST_CSW_FIELDS: assert property (
        @(posedge clk) disable iff (!reset_n)
        (cfgReq.wr && dwSel(cfgReq.addr, `PCHB_OFS_CSW_BASE) && cfgReq.byteEn == 4'hf)
        ##1 !(cfgReq.wr && dwSel(cfgReq.addr, `PCHB_OFS_CSW_BASE))
        ##1 (cfgReq.rd && dwSel(cfgReq.addr, `PCHB_OFS_CSW_BASE))
        |=> cfgRdata == ($past(cfgReq.wdata, 3) & `PCHB_CSW_MASK))
        else $error("Control space base readback wrong.");

    AST_RESET_ZERO: assert property (
        @(posedge clk)
        !reset_n |=> (scwBase_r == 32'h0 && cswBase_r == 32'h0 && !hitStatusCtrl))
        else $error("Window bases not zero after reset.");

    AST_NO_HIT_DISABLED: assert property (
        @(posedge clk) disable iff (!reset_n)
        (memReq.valid && !memReq.spaceEnable) |=> !(hitStatusCtrl || hitControlSpace))
        else $error("Hit while memory space disabled.");

    AST_HIT_MATCH: assert property (
        @(posedge clk) disable iff (!reset_n)
        hitControlSpace |-> ($past(memReq.addr[31:15]) == $past(cswBase_r[31:15])
                             && $past(memReq.valid)))
        else $error("Control space hit without address match.");

    AST_HIT_TAKEN: assert property (
        @(posedge clk) disable iff (!reset_n)
        (memReq.valid && memReq.spaceEnable
         && memReq.addr[31:12] == scwBase_r[31:12]) |=> hitStatusCtrl)
        else $error("Status/control hit missed.");

    AST_LATENCY_ZERO: assert property (
        @(posedge clk) disable iff (!reset_n)
        (cfgReq.rd && dwSel(cfgReq.addr, `PCHB_OFS_LATENCY)) |=> cfgRdata[15:8] == 8'h00)
        else $error("Latency timer byte not zero.");

    AST_SCW_NOPREFETCH: assert property (
        @(posedge clk) disable iff (!reset_n)
        (cfgReq.rd && dwSel(cfgReq.addr, `PCHB_OFS_SCW_BASE)) |=> !cfgRdata[3])
        else $error("Status/control base reports prefetchable.");

    AST_SCW_TYPE32: assert property (
        @(posedge clk) disable iff (!reset_n)
        (cfgReq.rd && dwSel(cfgReq.addr, `PCHB_OFS_SCW_BASE)) |=> cfgRdata[2:1] == 2'h0)
        else $error("Status/control base type bits not zero.");

    AST_SCW_MEMSPACE: assert property (
        @(posedge clk) disable iff (!reset_n)
        (cfgReq.rd && dwSel(cfgReq.addr, `PCHB_OFS_SCW_BASE)) |=> !cfgRdata[0])
        else $error("Status/control base reports I/O space.");

    AST_CSW_LOW_ZERO: assert property (
        @(posedge clk) disable iff (!reset_n)
        (cfgReq.rd && dwSel(cfgReq.addr, `PCHB_OFS_CSW_BASE)) |=> cfgRdata[14:0] == 15'h0000)
        else $error("Control space base low bits not zero.");

    AST_CSW_STORE: assert property (
        @(posedge clk) disable iff (!reset_n)
        (cfgReq.wr && dwSel(cfgReq.addr, `PCHB_OFS_CSW_BASE) && cfgReq.byteEn == 4'hf)
        |=> cswBase_r == ($past(cfgReq.wdata) & `PCHB_CSW_MASK))
        else $error("Control space base write not stored.");

    AST_SCW_HIT_MATCH: assert property (
        @(posedge clk) disable iff (!reset_n)
        hitStatusCtrl |-> ($past(memReq.addr[31:12]) == $past(scwBase_r[31:12])
                           && $past(memReq.valid)))
        else $error("Status/control hit without address match.");

    AST_HIT_ENABLED: assert property (
        @(posedge clk) disable iff (!reset_n)
        (hitStatusCtrl || hitControlSpace) |-> $past(memReq.spaceEnable))
        else $error("Hit without memory space enable.");

    AST_RESET_OUTPUTS: assert property (
        @(posedge clk)
        !reset_n |=> (!cfgRdValid && cfgRdata == 32'h0 && !hitControlSpace))
        else $error("Outputs not cleared by reset.");

endmodule // pchb_config_bars

// ---- pchb_host_model.sv ----
`timescale 1ns/100ps
module pchb_host_model
    import pchb_pkg::*;
(
    input  wire logic     clk,
    output pchb_cfg_req_t cfgReq,
    output pchb_mem_req_t memReq
);
    initial begin
        cfgReq = '0;
        memReq = '0;
    end
    // ------------------------------------------------------------------
    // Cycle drivers
    // ------------------------------------------------------------------
    // Strobes drop and the other lines are inverted after each request so stale values never pass.
    task automatic cfg(input logic r, input logic w, input logic [7:0] a,
                       input logic [3:0] be, input logic [31:0] d);
        @(posedge clk);
        #1;
        cfgReq = '{r, w, a, be, d};
        @(posedge clk);
        #1;
        cfgReq = '{1'b0, 1'b0, ~a, ~be, ~d};
    endtask
    task automatic mem(input logic en, input logic [31:0] a);
        @(posedge clk);
        #1;
        memReq = '{1'b1, en, a};
        @(posedge clk);
        #1;
        memReq = '{1'b0, ~en, ~a};
    endtask
endmodule // pchb_host_model

// ---- pchb_map.svh ----
`ifndef PCHB_MAP_SVH
`define PCHB_MAP_SVH

// ----------------------------------------------------------------------------
// Configuration offsets (byte addresses, dword aligned for decode)
// ----------------------------------------------------------------------------
`define PCHB_OFS_LATENCY      8'h0d
`define PCHB_OFS_HEADER       8'h0e
`define PCHB_OFS_SELFTEST     8'h0f
`define PCHB_OFS_DW_MISC      8'h0c
`define PCHB_OFS_SCW_BASE     8'h10
`define PCHB_OFS_CSW_BASE     8'h14

// ----------------------------------------------------------------------------
// Constant register values
// ----------------------------------------------------------------------------
`define PCHB_LATENCY_VAL      8'h00
`define PCHB_HEADER_VAL       8'h00
`define PCHB_SELFTEST_VAL     8'h00
`define PCHB_BASE_RST         32'h00000000

// ----------------------------------------------------------------------------
// Window base field layout
// ----------------------------------------------------------------------------
`define PCHB_SCW_MASK         32'hfffff000
`define PCHB_CSW_MASK         32'hffff8000
`define PCHB_SCW_LSB          12
`define PCHB_CSW_LSB          15

`endif

// ---- pchb_pkg.sv ----
package pchb_pkg;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [7:0]  addr;
        logic [3:0]  byteEn;
        logic [31:0] wdata;
    } pchb_cfg_req_t;

    typedef struct packed {
        logic        valid;
        logic        spaceEnable;
        logic [31:0] addr;
    } pchb_mem_req_t;

endpackage

// ---- tb.sv ----
`timescale 1ns/100ps
module tb
    import pchb_pkg::*;
;
    logic          clk = 1'b0;
    logic          reset_n = 1'b0;
    pchb_cfg_req_t cfgReq;
    pchb_mem_req_t memReq;
    logic [31:0]   cfgRdata, scw = '0, csw = '0, rdQ[$];
    logic          cfgRdValid, hitStatusCtrl, hitControlSpace, memPend = 1'b0;
    logic [1:0]    hitQ[$], hitExp;
    int            err_count = 0, checked = 0;
    initial forever #2.5 clk = ~clk;
    pchb_config_bars dut(.clk(clk), .reset_n(reset_n), .cfgReq(cfgReq), .cfgRdata(cfgRdata),
        .cfgRdValid(cfgRdValid), .memReq(memReq), .hitStatusCtrl(hitStatusCtrl),
        .hitControlSpace(hitControlSpace));
    pchb_host_model p(.clk(clk), .cfgReq(cfgReq), .memReq(memReq));
    // ------------------------------------------------------------------
    // Checking
    // ------------------------------------------------------------------
    task automatic cmp(input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    always @(negedge clk) begin
        if (cfgRdValid === 1'b1) cmp(rdQ.pop_front(), cfgRdata);
        if (memPend) begin
            hitExp = hitQ.pop_front();
            cmp({30'h0, hitExp}, {30'h0, hitStatusCtrl, hitControlSpace});
        end
        memPend = memReq.valid;
    end
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rdQ.push_back(e);
        p.cfg(1'b1, 1'b0, a, 4'h0, 32'h0);
    endtask
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        if (a == 8'h10) scw = ((scw & ~m) | (d & m)) & 32'hfffff000;
        if (a == 8'h14) csw = ((csw & ~m) | (d & m)) & 32'hffff8000;
        p.cfg(1'b0, 1'b1, a, be, d);
    endtask
    task automatic mem(input logic en, input logic [31:0] a);
        hitQ.push_back({en && a[31:12] == scw[31:12], en && a[31:15] == csw[31:15]});
        p.mem(en, a);
    endtask
    task automatic final_report;
        $display("checked=%0d err_count=%0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        logic [31:0] r;
        void'($urandom(32'he824));
        repeat (4) @(posedge clk);
        #1 reset_n = 1'b1;
        rd(8'h10, 32'h0);
        rd(8'h14, 32'h0);
        mem(1'b1, 32'h0);
        mem(1'b0, 32'h0);
        wr(8'h0c, 4'hf, 32'hffffffff);
        rd(8'h0c, 32'h0);
        wr(8'h18, 4'hf, 32'hffffffff);
        rd(8'h18, 32'h0);
        $display("test constants done");
        wr(8'h10, 4'hf, 32'hffffffff);
        rd(8'h10, 32'hfffff000);
        wr(8'h14, 4'hf, 32'hffffffff);
        rd(8'h14, 32'hffff8000);
        $display("test fixed bits done");
        repeat (24) begin
            r = $urandom;
            wr(r[0] ? 8'h14 : 8'h10, r[4:1], $urandom);
            rd(8'h10, scw);
            rd(8'h14, csw);
            mem(r[5], r[6] ? {scw[31:12], r[31:20]} : {csw[31:15], r[31:17]});
            mem(1'b1, {scw[31:12] ^ r[31:12], r[11:0]});
        end
        $display("test random windows done");
        repeat (3) @(posedge clk);
        cmp(32'h0, 32'(rdQ.size() + hitQ.size()));
        final_report;
    end
    initial begin
        #10000;
        err_count++;
        final_report;
    end
endmodule // tb
